// File: core/mhf_pkg.sv
`default_nettype none
package mhf_pkg;
  localparam logic [7:0] MHF_OFF_MC_LOW = 8'hAC;
  localparam logic [7:0] MHF_OFF_MC_HIGH = 8'hB0;
  localparam logic [7:0] MHF_OFF_UC_LOW = 8'hB4;
  localparam logic [7:0] MHF_OFF_UC_HIGH = 8'hB8;
  localparam logic [7:0] MHF_OFF_OPERATION_SELECT = 8'hFC;
  localparam logic [31:0] MHF_HASH_RESET = 32'h00000000;
  localparam logic [2:0] MHF_OPSEL_RESET = 3'h7;
  localparam logic [2:0] MHF_OPSEL_SINGLE = 3'h7;
  localparam logic [2:0] MHF_OPSEL_MAC_ONLY = 3'h4;
  localparam logic [2:0] MHF_RX_STOPPED = 3'h0;
  localparam int MHF_BIT_SPEED = 31;
  localparam int MHF_BIT_DUPLEX = 30;
  localparam int MHF_BIT_LINK = 29;
  localparam int MHF_BIT_RELOAD = 26;
  localparam int MHF_HALF_BIT = 5;
  localparam logic [31:0] MHF_CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] MHF_CRC_INIT = 32'hFFFFFFFF;
  localparam int MHF_DA_BYTES = 6;
  localparam logic [31:0] MHF_SLVERR_DATA = 32'h00000000;
endpackage
`default_nettype wire

// File: core/mhf_crc.sv
`default_nettype none
// Bytewise CRC32 over the destination address; hash index is low six bits
module mhf_crc
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic byte_vld,
  input wire logic [7:0] byte_data,
  input wire logic frame_start,
  output logic idx_vld,
  output logic [5:0] idx
);
  import mhf_pkg::*;
  logic [31:0] crc_r;
  logic [31:0] crc_nxt;
  logic [2:0] cnt_r;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[31] ^ d[i])
        r = (r << 1) ^ MHF_CRC_POLY;
      else
        r = r << 1;
    end
    return r;
  endfunction

  always_comb
  begin
    crc_nxt = crc_step(frame_start ? MHF_CRC_INIT : crc_r, byte_data);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      crc_r <= MHF_CRC_INIT;
      cnt_r <= 3'h0;
      idx_vld <= 1'b0;
      idx <= 6'h00;
    end
    else
    begin
      idx_vld <= 1'b0;
      if (byte_vld && (frame_start || cnt_r != 3'h0))
      begin
        crc_r <= crc_nxt;
        if ((frame_start ? 3'h0 : cnt_r) == 3'(MHF_DA_BYTES - 1))
        begin
          cnt_r <= 3'h0;
          idx_vld <= 1'b1;
          idx <= crc_nxt[5:0];
        end
        else
          cnt_r <= (frame_start ? 3'h1 : cnt_r + 3'h1);
      end
    end
  end
endmodule
`default_nettype wire

// File: core/mhf_reload.sv
`default_nettype none
// Handshake with the EEPROM loader: request held until done returns
module mhf_reload
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic done_pin,
  output logic busy,
  output logic req
);
  logic d1_r;
  logic d2_r;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      d1_r <= 1'b0;
      d2_r <= 1'b0;
    end
    else
    begin
      d1_r <= done_pin;
      d2_r <= d1_r;
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      req <= 1'b0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      req <= 1'b1;
    end
    else if (busy && d2_r)
    begin
      busy <= 1'b0;
      req <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: core/mhf_top.sv
`default_nettype none
module mhf_top
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] rx_state,
  input wire logic speed_pin,
  input wire logic duplex_pin,
  input wire logic link_pin,
  input wire logic reload_done_pin,
  output logic reload_req,
  input wire logic rx_byte_vld,
  input wire logic [7:0] rx_byte,
  input wire logic rx_frame_start,
  input wire logic rx_da_multicast,
  output logic hash_vld,
  output logic hash_accept,
  output logic [2:0] operation_select,
  output logic mac_only_mode,
  output logic diag_mode
);
  import mhf_pkg::*;

  logic [31:0] multicast_hash_low_r;
  logic [31:0] multicast_hash_high_r;
  logic [31:0] unicast_hash_low_r;
  logic [31:0] unicast_hash_high_r;
  logic [2:0] opsel_r;
  logic [2:0] st_s1_r;
  logic [2:0] st_s2_r;
  logic stop_seen_r;
  logic sp1_r;
  logic sp2_r;
  logic dp1_r;
  logic duplex_status;
  logic lk1_r;
  logic lk2_r;
  logic mc_seen_r;
  logic reload_busy;
  logic idx_vld;
  logic [5:0] idx;
  logic wr_en;
  logic rd_en;
  logic rx_stopped;
  logic [31:0] rd_nxt;
  logic hit_nxt;

  function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (st[b])
        r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic table_hit(input logic [31:0] lo, input logic [31:0] hi,
                                     input logic [5:0] ix);
    logic [31:0] w;
    w = ix[MHF_HALF_BIT] ? hi : lo;
    return w[ix[4:0]];
  endfunction

  function automatic logic known_off(input logic [7:0] a);
    return a == MHF_OFF_MC_LOW || a == MHF_OFF_MC_HIGH || a == MHF_OFF_UC_LOW ||
           a == MHF_OFF_UC_HIGH || a == MHF_OFF_OPERATION_SELECT;
  endfunction

  // Pin inputs pass two flip-flops before use
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_s1_r <= 3'h0;
      st_s2_r <= 3'h0;
      sp1_r <= 1'b0;
      sp2_r <= 1'b0;
      dp1_r <= 1'b0;
      duplex_status <= 1'b0;
      lk1_r <= 1'b0;
      lk2_r <= 1'b0;
    end
    else
    begin
      st_s1_r <= rx_state;
      st_s2_r <= st_s1_r;
      sp1_r <= speed_pin;
      sp2_r <= sp1_r;
      dp1_r <= duplex_pin;
      duplex_status <= dp1_r;
      lk1_r <= link_pin;
      lk2_r <= lk1_r;
    end
  end

  // A skewed state change can pass through 000 for one cycle; want two samples
  always_ff @(posedge core_clk)
  begin
    if (rst)
      stop_seen_r <= 1'b0;
    else
      stop_seen_r <= (st_s2_r == MHF_RX_STOPPED);
  end

  assign rx_stopped = stop_seen_r && (st_s2_r == MHF_RX_STOPPED);
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // Multicast table; writes dropped while receiver runs
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      multicast_hash_low_r <= MHF_HASH_RESET;
      multicast_hash_high_r <= MHF_HASH_RESET;
    end
    else if (wr_en && rx_stopped)
    begin
      if (paddr == MHF_OFF_MC_LOW)
        multicast_hash_low_r <= byte_merge(multicast_hash_low_r, pwdata, pstrb);
      if (paddr == MHF_OFF_MC_HIGH)
        multicast_hash_high_r <= byte_merge(multicast_hash_high_r, pwdata, pstrb);
    end
  end

  // Unicast table
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      unicast_hash_low_r <= MHF_HASH_RESET;
      unicast_hash_high_r <= MHF_HASH_RESET;
    end
    else if (wr_en)
    begin
      if (paddr == MHF_OFF_UC_LOW)
        unicast_hash_low_r <= byte_merge(unicast_hash_low_r, pwdata, pstrb);
      if (paddr == MHF_OFF_UC_HIGH)
        unicast_hash_high_r <= byte_merge(unicast_hash_high_r, pwdata, pstrb);
    end
  end

  // Mode field, low byte lane
  always_ff @(posedge core_clk)
  begin
    if (rst)
      opsel_r <= MHF_OPSEL_RESET;
    else if (wr_en && paddr == MHF_OFF_OPERATION_SELECT && pstrb[0])
      opsel_r <= pwdata[2:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      operation_select <= MHF_OPSEL_RESET;
      mac_only_mode <= 1'b0;
      diag_mode <= 1'b0;
    end
    else
    begin
      operation_select <= opsel_r;
      mac_only_mode <= (opsel_r == MHF_OPSEL_MAC_ONLY);
      diag_mode <= (opsel_r != MHF_OPSEL_SINGLE) &&
                   (opsel_r != MHF_OPSEL_MAC_ONLY);
    end
  end

  mhf_reload u_reload
  (
    .core_clk(core_clk),
    .rst(rst),
    .start(wr_en && paddr == MHF_OFF_OPERATION_SELECT && pstrb[3] && pwdata[MHF_BIT_RELOAD]),
    .done_pin(reload_done_pin),
    .busy(reload_busy),
    .req(reload_req)
  );

  always_comb
  begin
    rd_nxt = 32'h00000000;
    case (paddr)
      MHF_OFF_MC_LOW: rd_nxt = multicast_hash_low_r;
      MHF_OFF_MC_HIGH: rd_nxt = multicast_hash_high_r;
      MHF_OFF_UC_LOW: rd_nxt = unicast_hash_low_r;
      MHF_OFF_UC_HIGH: rd_nxt = unicast_hash_high_r;
      MHF_OFF_OPERATION_SELECT:
      begin
        rd_nxt[MHF_BIT_SPEED] = sp2_r;
        rd_nxt[MHF_BIT_DUPLEX] = duplex_status;
        rd_nxt[MHF_BIT_LINK] = lk2_r;
        rd_nxt[MHF_BIT_RELOAD] = reload_busy;
        rd_nxt[2:0] = opsel_r;
      end
      default: rd_nxt = MHF_SLVERR_DATA;
    endcase
  end

  // Zero-wait APB slave: answer in the access cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known_off(paddr);
      if (psel && !penable && !pwrite)
        prdata <= rd_nxt;
    end
  end

  mhf_crc u_crc
  (
    .core_clk(core_clk),
    .rst(rst),
    .byte_vld(rx_byte_vld),
    .byte_data(rx_byte),
    .frame_start(rx_frame_start),
    .idx_vld(idx_vld),
    .idx(idx)
  );

  always_ff @(posedge core_clk)
  begin
    if (rst)
      mc_seen_r <= 1'b0;
    else if (rx_frame_start && rx_byte_vld)
      mc_seen_r <= rx_da_multicast;
  end

  always_comb
  begin
    if (mc_seen_r)
      hit_nxt = table_hit(multicast_hash_low_r, multicast_hash_high_r, idx);
    else
      hit_nxt = table_hit(unicast_hash_low_r, unicast_hash_high_r, idx);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hash_vld <= 1'b0;
      hash_accept <= 1'b0;
    end
    else
    begin
      hash_vld <= idx_vld;
      hash_accept <= idx_vld && hit_nxt;
    end
  end

  a_mc_write_lock: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && !rx_stopped && paddr == MHF_OFF_MC_LOW) |=> $stable(multicast_hash_low_r))
    else $error("multicast table changed while receiver active");
  sequence s_operation_select_read;
    psel && !penable && !pwrite && paddr == MHF_OFF_OPERATION_SELECT;
  endsequence

  a_reload_clears: assert property (@(posedge core_clk) disable iff (rst)
    (reload_busy && $past(reload_done_pin, 3) && $past(reload_done_pin, 2)
     && $past(reload_busy)) |=> !reload_busy)
    else $error("reload bit not cleared after done");
  a_reload_set: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && paddr == MHF_OFF_OPERATION_SELECT && pstrb[3] && pwdata[MHF_BIT_RELOAD] && !reload_busy)
    |=> reload_req)
    else $error("reload request not raised");
  a_accept_table: assert property (@(posedge core_clk) disable iff (rst)
    (idx_vld && mc_seen_r) |=> (hash_accept == $past(idx[MHF_HALF_BIT] ?
    multicast_hash_high_r[idx[4:0]] : multicast_hash_low_r[idx[4:0]])))
    else $error("hash accept mismatch");
  a_accept_ucast: assert property (@(posedge core_clk) disable iff (rst)
    (idx_vld && !mc_seen_r) |=> (hash_accept == $past(idx[MHF_HALF_BIT] ?
    unicast_hash_high_r[idx[4:0]] : unicast_hash_low_r[idx[4:0]])))
    else $error("unicast accept mismatch");
  a_hash_pulse: assert property (@(posedge core_clk) disable iff (rst)
    hash_vld |=> !hash_vld)
    else $error("hash valid longer than one cycle");
  a_apb_ready: assert property (@(posedge core_clk) disable iff (rst)
    (psel && !penable) |=> pready)
    else $error("pready not raised in access cycle");
  a_read_ready: assert property (@(posedge core_clk) disable iff (rst)
    rd_en |-> pready)
    else $error("pready low in read access");
  a_unmapped_err: assert property (@(posedge core_clk) disable iff (rst)
    (psel && !penable && !known_off(paddr)) |=> pslverr)
    else $error("unmapped address without error");
  a_mode_flag: assert property (@(posedge core_clk) disable iff (rst)
    (opsel_r == MHF_OPSEL_MAC_ONLY) |=> mac_only_mode)
    else $error("mac only flag missing");
  a_mode_single: assert property (@(posedge core_clk) disable iff (rst)
    (opsel_r == MHF_OPSEL_SINGLE) |=> (!mac_only_mode && !diag_mode))
    else $error("single chip mode flags wrong");
  a_mode_diag: assert property (@(posedge core_clk) disable iff (rst)
    (opsel_r != MHF_OPSEL_SINGLE && opsel_r != MHF_OPSEL_MAC_ONLY) |=> diag_mode)
    else $error("diagnostic flag missing");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
    s_operation_select_read |=>
    (prdata[28:27] == 2'h0 && prdata[25:3] == 23'h0))
    else $error("reserved bits nonzero");
  a_uc_write: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && paddr == MHF_OFF_UC_LOW && pstrb == 4'hF) |=> (unicast_hash_low_r == $past(pwdata)))
    else $error("unicast write lost");
  a_mc_low_write: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && rx_stopped && paddr == MHF_OFF_MC_LOW && pstrb == 4'hF) |=>
    (multicast_hash_low_r == $past(pwdata)))
    else $error("multicast low write lost");
  a_mc_high_lane: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && rx_stopped && paddr == MHF_OFF_MC_HIGH && pstrb == 4'h8) |=>
    ($stable(multicast_hash_high_r[23:0]) &&
     multicast_hash_high_r[31:24] == $past(pwdata[31:24])))
    else $error("multicast high byte lane wrong");
  a_status_bits: assert property (@(posedge core_clk) disable iff (rst)
    s_operation_select_read |=>
    (prdata[MHF_BIT_LINK] == $past(lk2_r)))
    else $error("link status wrong");
  a_reset_values: assert property (@(posedge core_clk) $fell(rst) |->
    (multicast_hash_low_r == MHF_HASH_RESET && multicast_hash_high_r == MHF_HASH_RESET &&
     unicast_hash_low_r == MHF_HASH_RESET && unicast_hash_high_r == MHF_HASH_RESET &&
     opsel_r == MHF_OPSEL_RESET))
    else $error("registers not at reset values");
endmodule
`default_nettype wire

// File: tb/mhf_net_model.sv
`default_nettype none
// Network side: delivers destination addresses one byte per cycle
module mhf_net_model
(
  input wire logic core_clk,
  output logic rx_byte_vld,
  output logic [7:0] rx_byte,
  output logic rx_frame_start,
  output logic rx_da_multicast
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    rx_byte_vld = 1'b0;
    rx_byte = 8'h00;
    rx_frame_start = 1'b0;
    rx_da_multicast = 1'b0;
  end
  // First byte carries the group bit, which marks a multicast address
  task automatic send(input logic [47:0] da);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge core_clk);
      rx_byte_vld <= 1'b1;
      rx_byte <= da[47 - 8 * i -: 8];
      rx_frame_start <= (i == 0);
      rx_da_multicast <= (i == 0) & da[40];
    end
    @(posedge core_clk);
    rx_byte_vld <= 1'b0;
    rx_frame_start <= 1'b0;
    rx_da_multicast <= 1'b0;
    // Idle data must not look like the last byte
    rx_byte <= ~rx_byte;
  endtask
endmodule
`default_nettype wire

// File: tb/mhf_top_tb.sv
`default_nettype none
module mhf_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mhf_pkg::*;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, rx_byte;
  logic [31:0] pwdata, prdata, s, rd, v;
  logic [3:0] pstrb;
  logic [2:0] rx_state, operation_select, st;
  logic speed_pin, duplex_pin, link_pin, reload_done_pin, reload_req, err;
  logic rx_byte_vld, rx_frame_start, rx_da_multicast, hash_vld, hash_accept;
  logic mac_only_mode, diag_mode;
  logic [31:0] tbl [4];
  logic [7:0] offs [4] = '{MHF_OFF_MC_LOW, MHF_OFF_MC_HIGH, MHF_OFF_UC_LOW, MHF_OFF_UC_HIGH};
  logic [2:0] modes [4] = '{MHF_OPSEL_MAC_ONLY, 3'h2, 3'h0, MHF_OPSEL_SINGLE};
  int failures = 0;
  int cmp_count = 0;
  mhf_top i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_state(rx_state), .speed_pin(speed_pin),
    .duplex_pin(duplex_pin), .link_pin(link_pin), .reload_done_pin(reload_done_pin),
    .reload_req(reload_req), .rx_byte_vld(rx_byte_vld), .rx_byte(rx_byte),
    .rx_frame_start(rx_frame_start), .rx_da_multicast(rx_da_multicast),
    .hash_vld(hash_vld), .hash_accept(hash_accept), .operation_select(operation_select),
    .mac_only_mode(mac_only_mode), .diag_mode(diag_mode));
  mhf_net_model i_net (.core_clk(core_clk), .rx_byte_vld(rx_byte_vld), .rx_byte(rx_byte),
    .rx_frame_start(rx_frame_start), .rx_da_multicast(rx_da_multicast));
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Non-reflected register, wire order of bits, no final inversion
  function automatic logic [5:0] hidx(input logic [47:0] da);
    logic [31:0] c;
    logic fb;
    c = MHF_CRC_INIT;
    for (int i = 0; i < 6; i++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        fb = c[31] ^ da[40 - 8 * i + b];
        c = {c[30:0], 1'b0} ^ (fb ? MHF_CRC_POLY : 32'h00000000);
      end
    end
    return c[5:0];
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %0t word %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %0t flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] sb);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= sb;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      chk1(1'b0, 1'b1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000, 4'h0);
    chk32(rd, exp);
  endtask
  task automatic hash_try(input logic [47:0] da, input logic exp);
    int n;
    n = 0;
    i_net.send(da);
    while (hash_vld !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    chk1(hash_vld, 1'b1);
    chk1(hash_accept, exp);
  endtask
  initial
  begin
    #1000000;
    chk1(1'b0, 1'b1);
    finish_test();
  end
  initial
  begin
    logic [47:0] da;
    logic [63:0] m;
    logic [5:0] ix;
    logic [7:0] base;
    s = 32'h00000002;
    {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {1'b1, 47'h0};
    {rx_state, speed_pin, duplex_pin, link_pin, reload_done_pin} = 7'h0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
      rdchk(offs[i], MHF_HASH_RESET);
    rdchk(MHF_OFF_OPERATION_SELECT, {29'h0, MHF_OPSEL_RESET});
    chk32({29'h0, operation_select}, 32'h00000007);
    rdchk(8'h10, MHF_SLVERR_DATA);
    chk1(err, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      tbl[i] = rnd();
      apb(1'b1, offs[i], tbl[i], 4'hF);
      rdchk(offs[i], tbl[i]);
    end
    v = rnd();
    apb(1'b1, MHF_OFF_MC_HIGH, v, 4'h8);
    rdchk(MHF_OFF_MC_HIGH, {v[31:24], tbl[1][23:0]});
    apb(1'b1, MHF_OFF_UC_HIGH, v, 4'h1);
    rdchk(MHF_OFF_UC_HIGH, {tbl[3][31:8], v[7:0]});
    rx_state <= 3'h1;
    repeat (4) @(posedge core_clk);
    apb(1'b1, MHF_OFF_MC_LOW, ~tbl[0], 4'hF);
    rdchk(MHF_OFF_MC_LOW, tbl[0]);
    apb(1'b1, MHF_OFF_UC_LOW, ~tbl[2], 4'hF);
    rdchk(MHF_OFF_UC_LOW, ~tbl[2]);
    rx_state <= MHF_RX_STOPPED;
    repeat (4) @(posedge core_clk);
    for (int k = 0; k < 12; k++)
    begin
      da = 48'({rnd(), rnd()});
      da[40] = k[0];
      ix = hidx(da);
      m = (64'h1 << ix) ^ (k[1] ? 64'hFFFFFFFFFFFFFFFF : 64'h0);
      base = k[0] ? MHF_OFF_MC_LOW : MHF_OFF_UC_LOW;
      apb(1'b1, base, m[31:0], 4'hF);
      apb(1'b1, base + 8'h04, m[63:32], 4'hF);
      apb(1'b1, k[0] ? MHF_OFF_UC_LOW : MHF_OFF_MC_LOW, ~m[31:0], 4'hF);
      apb(1'b1, k[0] ? MHF_OFF_UC_HIGH : MHF_OFF_MC_HIGH, ~m[63:32], 4'hF);
      hash_try(da, ~k[1]);
    end
    st = 3'(rnd());
    {speed_pin, duplex_pin, link_pin} <= st;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, MHF_OFF_OPERATION_SELECT, 32'hF9FFFFF8 | modes[i], 4'hF);
      rdchk(MHF_OFF_OPERATION_SELECT, {st, 26'h0, modes[i]});
      chk1(mac_only_mode, modes[i] == MHF_OPSEL_MAC_ONLY);
      chk1(diag_mode, modes[i] != 3'h7 && modes[i] != 3'h4);
      chk32({29'h0, operation_select}, {29'h0, modes[i]});
    end
    apb(1'b1, MHF_OFF_OPERATION_SELECT, 32'h04000007, 4'hF);
    rdchk(MHF_OFF_OPERATION_SELECT, {st, 26'h0, 3'h7} | 32'h04000000);
    chk1(reload_req, 1'b1);
    reload_done_pin <= 1'b1;
    for (int n = 0; n < 20 && reload_req !== 1'b0; n++)
      @(posedge core_clk);
    reload_done_pin <= 1'b0;
    rdchk(MHF_OFF_OPERATION_SELECT, {st, 26'h0, 3'h7});
    chk1(reload_req, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
